// ### logic/sar_conversion_sequencer.sv
// Successive-approximation conversion sequencer with saturating output
//
// Operation
// - Acquisition grounds array tops, switches track inputs
// - Convert rising edge after acquisition starts conversion
// - Open ground switches before moving arrays to ground
// - Convert value captured when acquisition ends
// - Eighteen MSB-first trials, keep bit per comparator
// - After last trial return to acquisition, flag done
// - Trials timed by internal clock, never serial clock
// - Result belongs to this conversion, no latency
// - Power down between conversions
// - Rate up to 400k; host spaces edges accordingly
// - Output is 18-bit two's complement
// - Over-range saturates to maximum positive code
// - Under-range saturates to most negative code unless over-range is also set
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer
   import sar_seq_pkg::*;
#(
   parameter int N = RES_BITS
) (
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   input  wire logic         convert_trigger,
   input  wire logic         comp_out,
   input  wire logic         over_range,
   input  wire logic         under_range,
   output var  logic         positive_ground_switch,
   output var  logic         negative_ground_switch,
   output var  logic         array_to_input,
   output var  logic         array_to_ground,
   output var  logic [N-1:0] dac_ctrl,
   output var  logic         comp_enable,
   output var  logic         power_up,
   output var  logic         busy,
   output var  logic         conv_done,
   output var  logic [N-1:0] result,
   output var  logic         rate_violation
);
   // ------------------------------------------------------------
   // State and datapath registers
   // ------------------------------------------------------------
   localparam int BW = $clog2(N);
   localparam int PW = $clog2(MIN_PERIOD_CYC + 1);
   localparam logic [BW-1:0] TOP_IDX = BW'(N - 1);
   localparam logic [PW-1:0] PERIOD  = PW'(MIN_PERIOD_CYC);

   seq_state_t     state_r, state_nxt;
   logic [N-1:0]   sar_r, sar_nxt;
   logic [N-1:0]   trial_r, trial_nxt;
   logic [BW-1:0]  bit_r, bit_nxt;
   logic           cnv_q_r;
   logic           ovr_r, ovr_nxt;
   logic           und_r, und_nxt;
   logic [PW-1:0]  gap_r;
   logic           step_en;
   logic [N-1:0]   cur_mask;
   logic [N-1:0]   nxt_mask;
   logic [N-1:0]   decided;
   logic [N-1:0]   next_try;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire cnv_rise  = convert_trigger & ~cnv_q_r;
   wire idle      = (state_r == ST_ACQ) | (state_r == ST_SLEEP);
   wire start     = idle & cnv_rise;
   wire too_soon  = cnv_rise & (gap_r != '0);
   wire last_bit  = (bit_r == '0);
   wire run_steps = ~idle;
   wire in_finish = (state_r == ST_FINISH);
   // Offset binary from the array becomes two's complement by MSB flip
   wire [N-1:0] twos = {~sar_r[N-1], sar_r[N-2:0]};
   wire [N-1:0] code = ovr_r ? CODE_POS_MAX :
                       und_r ? CODE_NEG_MAX : twos;

   // ------------------------------------------------------------
   // Per-bit trial decode
   // ------------------------------------------------------------
   // One-hot masks keep the bit update free of variable-index writes
   for (genvar i = 0; i < N; i++) begin : g_bit
      assign cur_mask[i] = (bit_r == BW'(i));
      if (i < N - 1) begin : g_below
         assign nxt_mask[i] = cur_mask[i + 1];
      end else begin : g_top
         assign nxt_mask[i] = 1'b0;
      end
      // Comparator high means the trial overshot: drop that bit
      assign decided[i]  = trial_r[i] & ~(cur_mask[i] & comp_out);
      assign next_try[i] = decided[i] | nxt_mask[i];
   end

   // Internal conversion clock; serial clock never enters here
   step_divider #(
      .DIV     (STEP_DIV)
   ) u_div (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .run     (run_steps),
      .step_en (step_en)
   );

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      sar_nxt   = sar_r;
      trial_nxt = trial_r;
      bit_nxt   = bit_r;
      ovr_nxt   = ovr_r;
      und_nxt   = und_r;
      unique case (state_r)
         ST_ACQ: begin
            // One tracking cycle after a result, then sleep; power is already down in both
            if (start) begin
               state_nxt = ST_OPEN;
               ovr_nxt   = over_range;
               und_nxt   = under_range;
            end else begin
               state_nxt = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (start) begin
               state_nxt = ST_OPEN;
               // Range flags sampled with the input, at the edge
               ovr_nxt   = over_range;
               und_nxt   = under_range;
            end
         end
         ST_OPEN: begin
            if (step_en) begin
               state_nxt = ST_HOLD;
               // Every element back to ground while the charge is held
               trial_nxt = '0;
            end
         end
         ST_HOLD: begin
            if (step_en) begin
               state_nxt = ST_TRIAL;
               bit_nxt   = TOP_IDX;
               sar_nxt   = '0;
               trial_nxt = '0;
               trial_nxt[N-1] = 1'b1;
            end
         end
         ST_TRIAL: begin
            if (step_en) begin
               sar_nxt = decided;
               if (last_bit) begin
                  state_nxt = ST_FINISH;
                  trial_nxt = decided;
               end else begin
                  bit_nxt   = bit_r - 1'b1;
                  trial_nxt = next_try;
               end
            end
         end
         ST_FINISH: begin
            state_nxt = ST_ACQ;
         end
         default: begin
            state_nxt = ST_SLEEP;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Sequencer registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_SLEEP;
         sar_r   <= '0;
         trial_r <= '0;
         bit_r   <= '0;
         ovr_r   <= 1'b0;
         und_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sar_r   <= sar_nxt;
         trial_r <= trial_nxt;
         bit_r   <= bit_nxt;
         ovr_r   <= ovr_nxt;
         und_r   <= und_nxt;
      end
   end

   // ------------------------------------------------------------
   // Convert edge detector
   // ------------------------------------------------------------
   // Starts low, so a level already high at release counts as a rise
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnv_q_r <= 1'b0;
      end else begin
         cnv_q_r <= convert_trigger;
      end
   end

   // ------------------------------------------------------------
   // Spacing monitor
   // ------------------------------------------------------------
   // Edges closer than the rated period are flagged; ignored while a conversion runs, accepted once idle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gap_r <= '0;
      end else if (start) begin
         gap_r <= PERIOD - 1'b1;
      end else if (gap_r != '0) begin
         gap_r <= gap_r - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rate_violation <= 1'b0;
      end else begin
         rate_violation <= too_soon;
      end
   end

   // ------------------------------------------------------------
   // Switch and comparator outputs
   // ------------------------------------------------------------
   // Ground switches close only in tracking; arrays leave inputs
   // one step after the switches open, so charge is trapped cleanly
   wire track_nxt = (state_nxt == ST_ACQ) | (state_nxt == ST_SLEEP);
   wire open_nxt  = (state_nxt == ST_OPEN);
   wire gnd_nxt   = (state_nxt == ST_HOLD) | (state_nxt == ST_TRIAL);
   wire trial_go  = (state_nxt == ST_TRIAL);
   wire [N-1:0] dac_nxt = trial_nxt & {N{gnd_nxt}};

   // Both ground switches move together on the same edge
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         positive_ground_switch <= 1'b1;
         negative_ground_switch <= 1'b1;
      end else begin
         positive_ground_switch <= track_nxt;
         negative_ground_switch <= track_nxt;
      end
   end

   // Array terminals: inputs while tracking and during the open step
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         array_to_input  <= 1'b1;
         array_to_ground <= 1'b0;
      end else begin
         array_to_input  <= track_nxt | open_nxt;
         array_to_ground <= gnd_nxt;
      end
   end

   // Element switches and comparator follow the trial register
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dac_ctrl    <= '0;
         comp_enable <= 1'b0;
      end else begin
         dac_ctrl    <= dac_nxt;
         comp_enable <= trial_go;
      end
   end

   // ------------------------------------------------------------
   // Power and busy
   // ------------------------------------------------------------
   // Core power only while converting, so idle draw tracks the rate
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         power_up <= 1'b0;
         busy     <= 1'b0;
      end else begin
         power_up <= ~track_nxt;
         busy     <= ~track_nxt;
      end
   end

   // ------------------------------------------------------------
   // Result register
   // ------------------------------------------------------------
   // Done pulse lines up with the result update for the host
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         conv_done <= 1'b0;
      end else begin
         conv_done <= in_finish;
      end
   end

   // Code held until the next conversion completes
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         result <= RESULT_RST;
      end else if (in_finish) begin
         result <= code;
      end
   end

endmodule : sar_conversion_sequencer
`default_nettype wire

// ### inc/sar_seq_pkg.sv
// Package: constants and types for the conversion sequencer
`default_nettype none
package sar_seq_pkg;

   localparam int          RES_BITS        = 18;
   // Convert-rate ceiling and derived minimum spacing between convert edges
   localparam int          MAX_RATE_SPS    = 400000;
   localparam int          CLK_HZ          = 50000000;
   localparam int          MIN_PERIOD_CYC  = CLK_HZ / MAX_RATE_SPS;
   // Internal conversion clock divider (one step per enable pulse)
   localparam int          STEP_DIV        = 2;
   // Output code landmarks
   localparam logic [17:0] CODE_ZERO       = 18'h00000;
   localparam logic [17:0] CODE_POS_MAX    = 18'h1FFFF;
   localparam logic [17:0] CODE_NEG_MAX    = 18'h20000;
   localparam logic [17:0] RESULT_RST      = 18'h00000;
   localparam int          TOP_BIT         = RES_BITS - 1;

   typedef enum logic [5:0] {
      ST_ACQ    = 6'b000001,
      ST_OPEN   = 6'b000010,
      ST_HOLD   = 6'b000100,
      ST_TRIAL  = 6'b001000,
      ST_FINISH = 6'b010000,
      ST_SLEEP  = 6'b100000
   } seq_state_t;

endpackage : sar_seq_pkg
`default_nettype wire

// ### logic/step_divider.sv
// Step enable divider: internal conversion clock as a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module step_divider
   import sar_seq_pkg::*;
#(
   parameter int DIV = STEP_DIV
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic run,
   output var  logic step_en
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_r;
   wire           wrap = (cnt_r == LAST);

   // Stops while idle so the divider burns nothing between conversions
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt_r   <= '0;
         step_en <= 1'b0;
      end else if (!run) begin
         cnt_r   <= '0;
         step_en <= 1'b0;
      end else begin
         cnt_r   <= wrap ? '0 : cnt_r + 1'b1;
         step_en <= wrap;
      end
   end
endmodule : step_divider
`default_nettype wire

// ### tb/sar_seq_checker.sv
// Port assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_seq_checker #(
   parameter int N = 18
) (
   input wire logic         clk_sys,
   input wire logic         nrst,
   input wire logic         convert_trigger,
   input wire logic         positive_ground_switch,
   input wire logic         negative_ground_switch,
   input wire logic         array_to_input,
   input wire logic         array_to_ground,
   input wire logic [N-1:0] dac_ctrl,
   input wire logic         comp_enable,
   input wire logic         power_up,
   input wire logic         busy,
   input wire logic         conv_done,
   input wire logic [N-1:0] result,
   input wire logic         rate_violation
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   chk_idle_track:
      assert property (!busy |-> positive_ground_switch
         && negative_ground_switch && array_to_input)
      else $error("switches open while idle");
   chk_start_conv:
      assert property ($rose(convert_trigger) && !busy |=> busy
         && power_up && !positive_ground_switch)
      else $error("convert edge did not start");
   chk_switch_order:
      assert property ($rose(array_to_ground) |-> !array_to_input
         && !negative_ground_switch && !$past(positive_ground_switch))
      else $error("arrays moved before ground switches opened");
   chk_trial_count:
      assert property ($rose(busy) |-> (!conv_done)[*8] ##34 (!conv_done)
         ##1 conv_done)
      else $error("conversion length wrong");
   chk_done_return:
      assert property (conv_done |-> !busy && array_to_input
         && $past(busy))
      else $error("no return to acquisition at done");
   chk_result_hold:
      assert property ($changed(result) |-> conv_done)
      else $error("result moved without done");
   chk_power_down:
      assert property (!busy && !conv_done |-> !power_up)
      else $error("powered while idle");
   chk_rate_flag:
      assert property (rate_violation |-> $past(convert_trigger)
         && !$past(convert_trigger, 2))
      else $error("rate flag without convert edge");
   chk_msb_first:
      assert property ($rose(comp_enable) |-> dac_ctrl[N-1]
         && dac_ctrl[N-2:0] == '0)
      else $error("first trial is not the top element");
   chk_hold_ground:
      assert property (array_to_ground && !comp_enable |-> dac_ctrl == '0)
      else $error("element switched during charge hold");
endmodule : sar_seq_checker
bind sar_conversion_sequencer sar_seq_checker #(.N(N)) chk (.*);
`default_nettype wire

// ### tb/sar_host_model.sv
// Host and comparator model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_host_model (
   input  wire logic        clk_sys,
   input  wire logic [17:0] dac_ctrl,
   input  wire logic        comp_enable,
   input  wire logic [17:0] target,
   output var  logic        convert_trigger,
   output var  logic        comp_out
);
   logic [17:0] level;
   assign level = target ^ 18'h20000;
   initial convert_trigger = 1'b0;
   initial comp_out = 1'b0;
   // Outside trials the decision means nothing, so it toggles
   always @(negedge clk_sys) begin
      if (comp_enable) begin
         comp_out <= dac_ctrl > level;
      end else begin
         comp_out <= ~comp_out;
      end
   end
   // Caller keeps edges far enough apart unless a test wants otherwise
   task automatic start;
      @(negedge clk_sys);
      convert_trigger = 1'b1;
      repeat (4) @(negedge clk_sys);
      convert_trigger = 1'b0;
   endtask : start
endmodule : sar_host_model
`default_nettype wire

// ### tb/tb_sar_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_sar_conversion_sequencer import sar_seq_pkg::*;;
   logic clk_sys, nrst, convert_trigger, comp_out, over_range, under_range;
   logic positive_ground_switch, negative_ground_switch, array_to_input;
   logic array_to_ground, comp_enable, power_up, busy, conv_done;
   logic rate_violation;
   logic [17:0] dac_ctrl, result, target;
   int n_mismatch = 0, checked = 0, n_done = 0, n_rv = 0, rv0;
   int q[$];
   int codes[6] = '{'h00000, 'h3FFFF, 'h20000, 'h1FFFF, 'h00001, 'h20001};
   sar_conversion_sequencer dut (.*);
   sar_host_model host (.clk_sys, .dac_ctrl, .comp_enable, .target,
      .convert_trigger, .comp_out);
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic check(string name, logic [17:0] seen, logic [17:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic results;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   // Every published result is compared with the queued expectation
   always @(negedge clk_sys) begin
      if (rate_violation === 1'b1) n_rv++;
      if (conv_done === 1'b1) begin
         n_done++;
         check("queue", q.size() != 0, 1);
         check("result", result, q.size() ? q.pop_front() : 0);
      end
   end
   task automatic conv(int t, bit ov, bit un, bit again, int gap);
      int d;
      d = n_done;
      @(negedge clk_sys);
      target = t[17:0];
      over_range = ov;
      under_range = un;
      q.push_back(ov ? 'h1FFFF : un ? 'h20000 : t & 'h3FFFF);
      host.start();
      if (again) host.start();
      for (int i = 0; i < 100 && n_done == d; i++) @(negedge clk_sys);
      repeat (gap) @(negedge clk_sys);
      check("done_count", n_done - d, 1);
   endtask : conv
   initial begin
      nrst = 1'b0;
      over_range = 1'b0;
      under_range = 1'b0;
      target = 18'h00000;
      void'($urandom(99342));
      repeat (16) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (2) @(negedge clk_sys);
      check("idle", {positive_ground_switch, array_to_input, power_up},
         3'b110);
      foreach (codes[i]) conv(codes[i], 0, 0, 0, 100);
      $display("boundary codes finished");
      repeat (8) conv($urandom, 0, 0, 0, 100);
      $display("random codes finished");
      conv($urandom, 1, 0, 0, 100);
      conv($urandom, 0, 1, 0, 100);
      conv($urandom, 1, 1, 0, 100);
      check("no_rate_flag", n_rv, 0);
      $display("range limits finished");
      conv($urandom, 0, 0, 1, 100);
      rv0 = n_rv;
      conv($urandom, 0, 0, 0, 0);
      conv($urandom, 0, 0, 0, 100);
      check("rate_flag", n_rv - rv0, 1);
      $display("edge spacing finished");
      results();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      results();
   end
endmodule : tb_sar_conversion_sequencer
`default_nettype wire
